// [logic/cbu_branch_unit.sv]
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Carry-set jumps only when carry is one; carry-clear only when carry is zero.
// - Unsigned same-or-higher jumps when carry is zero, like carry-clear.
// - Lower jumps on carry one; negative on N one; positive on N zero.
// - Signed greater-or-equal jumps when N xor V is zero.
// - Signed less-than jumps when N xor V is one.
// - Half-carry-set jumps when H is one, else falls through.
// - Taken target is PC plus offset plus one; otherwise PC plus one.
// - Each of these jumps takes one or two cycles by outcome.
// - No status flag is altered by these jumps.
module cbu_branch_unit import cbu_pkg::*; #(
  parameter int PC_W = 16,
  parameter int OFFSET_W = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic br_valid,
  input wire logic [3:0] br_kind,
  input wire logic [OFFSET_W-1:0] br_offset,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [3:0] flags_in,
  output logic pc_load,
  output logic [PC_W-1:0] pc_target,
  output logic flush,
  output logic done,
  output logic taken,
  output logic busy,
  output logic [3:0] flags_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  cbu_state_t state;
  logic enable;
  logic bad_kind;
  logic [3:0] last_kind;
  logic [31:0] taken_cnt;
  logic [31:0] exec_cnt;
  logic accept;
  logic cond;
  logic kind_ok;
  logic [PC_W-1:0] calc_target;
  logic [PC_W-1:0] held_target;

  assign accept = br_valid && (state == CBU_IDLE) && enable;

  always_comb begin
    cond = 1'b0;
    kind_ok = 1'b1;
    case (br_kind)
      KIND_JUMP_ON_CARRY_SET: cond = flags_in[FLAG_C];
      KIND_JUMP_ON_CARRY_CLEAR: cond = !flags_in[FLAG_C];
      KIND_JUMP_ON_UNSIGNED_SAME_OR_HIGHER: cond = !flags_in[FLAG_C];
      KIND_JUMP_ON_UNSIGNED_LOWER: cond = flags_in[FLAG_C];
      KIND_JUMP_ON_NEGATIVE: cond = flags_in[FLAG_N];
      KIND_JUMP_ON_POSITIVE: cond = !flags_in[FLAG_N];
      KIND_JUMP_ON_SIGNED_GE: cond = !(flags_in[FLAG_N] ^ flags_in[FLAG_V]);
      KIND_JUMP_ON_SIGNED_LT: cond = flags_in[FLAG_N] ^ flags_in[FLAG_V];
      KIND_JUMP_ON_HALF_CARRY_SET: cond = flags_in[FLAG_H];
      default: kind_ok = 1'b0;
    endcase
  end

  // Sign extension before the add keeps backward jumps correct
  assign calc_target = pc_in + {{(PC_W-OFFSET_W){br_offset[OFFSET_W-1]}}, br_offset}
                       + PC_W'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CBU_IDLE;
      pc_load <= 1'b0;
      pc_target <= '0;
      held_target <= '0;
      flush <= 1'b0;
      done <= 1'b0;
      taken <= 1'b0;
      busy <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      flush <= 1'b0;
      done <= 1'b0;
      case (state)
        CBU_IDLE: begin
          if (accept && cond) begin
            // The sequential word already fetched must not execute
            flush <= 1'b1;
            busy <= 1'b1;
            held_target <= calc_target;
            state <= CBU_SECOND;
          end else if (accept) begin
            pc_load <= 1'b1;
            pc_target <= pc_in + PC_W'(1);
            done <= 1'b1;
            taken <= 1'b0;
          end
        end
        CBU_SECOND: begin
          pc_load <= 1'b1;
          pc_target <= held_target;
          done <= 1'b1;
          taken <= 1'b1;
          busy <= 1'b0;
          state <= CBU_IDLE;
        end
        default: state <= CBU_IDLE;
      endcase
    end
  end

  // Flags pass back untouched; the status register sees no change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_out <= '0;
    end else if (accept) begin
      flags_out <= flags_in;
    end
  end

  // Register bus
  logic aw_held;
  logic w_held;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;
  logic [31:0] rd_word;
  logic rd_ok;
  logic clr_bad;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign clr_bad = do_write && (waddr == ADDR_STATUS) && wstrb[0] && wdata[STAT_BAD_KIND];

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_bvalid = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) next_aw_held = 1'b1;
    if (s_axi_wvalid && s_axi_wready) next_w_held = 1'b1;
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
    end
    next_rvalid = s_axi_rvalid;
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) next_rvalid = 1'b1;
  end

  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr == ADDR_CTRL) begin
      rd_word[CTRL_ENABLE] = enable;
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_word[STAT_BUSY] = busy;
      rd_word[STAT_LAST_TAKEN] = taken;
      rd_word[STAT_BAD_KIND] = bad_kind;
      rd_word[STAT_KIND_LSB +: 4] = last_kind;
    end else if (s_axi_araddr == ADDR_TAKEN_CNT) begin
      rd_word = taken_cnt;
    end else if (s_axi_araddr == ADDR_EXEC_CNT) begin
      rd_word = exec_cnt;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= '0;
      wdata <= '0;
      wstrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_bvalid <= next_bvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_arready <= !next_rvalid;
      if (s_axi_awvalid && s_axi_awready) waddr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= (waddr == ADDR_CTRL || waddr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Bookkeeping; an unknown kind never jumps and is flagged, set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= CTRL_ENABLE_RST;
      bad_kind <= 1'b0;
      last_kind <= '0;
      taken_cnt <= '0;
      exec_cnt <= '0;
    end else begin
      if (do_write && waddr == ADDR_CTRL && wstrb[0]) enable <= wdata[CTRL_ENABLE];
      if (accept && !kind_ok) bad_kind <= 1'b1;
      else if (clr_bad) bad_kind <= 1'b0;
      if (accept) begin
        last_kind <= br_kind;
        exec_cnt <= exec_cnt + 32'h1;
      end
      if (accept && cond) taken_cnt <= taken_cnt + 32'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_NOT_TAKEN_ONE: assert property (
    accept && !cond |=> done && pc_load && !taken && !flush)
    else $error("not-taken jump did not finish in one cycle");
  AST_TAKEN_TWO: assert property (
    accept && cond |=> flush && busy && !done ##1 done && pc_load && taken && !busy)
    else $error("taken jump did not finish in two cycles");
  AST_TAKEN_TARGET: assert property (
    accept && cond |-> ##2 pc_target == $past(calc_target, 2))
    else $error("taken target wrong");
  AST_FALL_TARGET: assert property (
    accept && !cond |=> pc_target == $past(pc_in) + PC_W'(1))
    else $error("fall-through target wrong");
  AST_BACKWARD: assert property (
    accept && cond && br_offset == '1 |-> ##2 pc_target == $past(pc_in, 2))
    else $error("offset not sign-extended");
  AST_CARRY: assert property (
    accept && br_kind == KIND_JUMP_ON_CARRY_CLEAR |=> flush == !$past(flags_in[FLAG_C]))
    else $error("carry-clear decision wrong");
  AST_SAME_HIGHER: assert property (
    accept && br_kind == KIND_JUMP_ON_UNSIGNED_SAME_OR_HIGHER
    |=> flush == !$past(flags_in[FLAG_C]))
    else $error("same-or-higher decision wrong");
  AST_NEGATIVE: assert property (
    accept && br_kind == KIND_JUMP_ON_NEGATIVE |=> flush == $past(flags_in[FLAG_N]))
    else $error("negative decision wrong");
  AST_SIGNED_GE: assert property (
    accept && br_kind == KIND_JUMP_ON_SIGNED_GE
    |=> flush == ($past(flags_in[FLAG_N]) == $past(flags_in[FLAG_V])))
    else $error("signed ge decision wrong");
  AST_SIGNED_LT: assert property (
    accept && br_kind == KIND_JUMP_ON_SIGNED_LT
    |=> flush == ($past(flags_in[FLAG_N]) != $past(flags_in[FLAG_V])))
    else $error("signed lt decision wrong");
  AST_HALF: assert property (
    accept && br_kind == KIND_JUMP_ON_HALF_CARRY_SET |=> flush == $past(flags_in[FLAG_H]))
    else $error("half-carry decision wrong");
  AST_FLAGS_KEPT: assert property (
    accept |=> flags_out == $past(flags_in) ##1 $stable(flags_out) || $past(accept))
    else $error("flags altered");

  COV_TAKEN: cover property (accept && cond ##2 done);
  COV_NOT_TAKEN: cover property (accept && !cond ##1 done);
  COV_BACK_TO_BACK: cover property (accept && !cond ##1 accept && cond);
endmodule : cbu_branch_unit

// [pkg/cbu_pkg.sv]
package cbu_pkg;
  // Branch kind codes presented by the instruction decoder
  localparam logic [3:0] KIND_JUMP_ON_CARRY_SET = 4'h0;
  localparam logic [3:0] KIND_JUMP_ON_CARRY_CLEAR = 4'h1;
  localparam logic [3:0] KIND_JUMP_ON_UNSIGNED_SAME_OR_HIGHER = 4'h2;
  localparam logic [3:0] KIND_JUMP_ON_UNSIGNED_LOWER = 4'h3;
  localparam logic [3:0] KIND_JUMP_ON_NEGATIVE = 4'h4;
  localparam logic [3:0] KIND_JUMP_ON_POSITIVE = 4'h5;
  localparam logic [3:0] KIND_JUMP_ON_SIGNED_GE = 4'h6;
  localparam logic [3:0] KIND_JUMP_ON_SIGNED_LT = 4'h7;
  localparam logic [3:0] KIND_JUMP_ON_HALF_CARRY_SET = 4'h8;

  // Flag vector layout {h, v, n, c}
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 1;
  localparam int FLAG_V = 2;
  localparam int FLAG_H = 3;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TAKEN_CNT = 8'h08;
  localparam logic [7:0] ADDR_EXEC_CNT = 8'h0c;

  // Field positions
  localparam int CTRL_ENABLE = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_LAST_TAKEN = 1;
  localparam int STAT_BAD_KIND = 2;
  localparam int STAT_KIND_LSB = 8;

  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam int CYC_NOT_TAKEN = 1;
  localparam int CYC_TAKEN = 2;

  typedef enum logic [0:0] {CBU_IDLE, CBU_SECOND} cbu_state_t;
endpackage : cbu_pkg

// [tb/test_conditional_branch_unit.sv]
`timescale 1ns/1ps
module test_conditional_branch_unit import cbu_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, br_valid = 1'b0;
  logic [3:0] br_kind = 4'h0, flags_in = 4'h0, s_axi_wstrb = 4'h0, flags_out;
  logic [6:0] br_offset = 7'h00;
  logic [15:0] pc_in = 16'h0000, pc_target;
  logic pc_load, flush, done, taken, busy;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int error_cnt = 0, samples_checked = 0, n_taken = 0, n_exec = 0;

  cbu_branch_unit cbu_branch_unit_i (.aclk, .aresetn, .br_valid, .br_kind, .br_offset,
    .pc_in, .flags_in, .pc_load, .pc_target, .flush, .done, .taken, .busy, .flags_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  always #5 aclk = ~aclk;

  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic exp_take(logic [3:0] k, logic [3:0] f);
    case (k)
      KIND_JUMP_ON_CARRY_SET: return f[FLAG_C];
      KIND_JUMP_ON_CARRY_CLEAR: return !f[FLAG_C];
      KIND_JUMP_ON_UNSIGNED_SAME_OR_HIGHER: return !f[FLAG_C];
      KIND_JUMP_ON_UNSIGNED_LOWER: return f[FLAG_C];
      KIND_JUMP_ON_NEGATIVE: return f[FLAG_N];
      KIND_JUMP_ON_POSITIVE: return !f[FLAG_N];
      KIND_JUMP_ON_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
      KIND_JUMP_ON_SIGNED_LT: return f[FLAG_N] ^ f[FLAG_V];
      KIND_JUMP_ON_HALF_CARRY_SET: return f[FLAG_H];
      default: return 1'b0;
    endcase
  endfunction : exp_take

  task automatic axi_wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      test_done();
    end
  endtask : axi_wr

  task automatic axi_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      test_done();
    end
  endtask : axi_rd

  // Hold keeps the request up into the busy cycle, where it must be ignored
  task automatic jump(logic [3:0] k, logic [6:0] o, logic [15:0] p, logic [3:0] f, logic hold);
    logic t;
    logic fs;
    int n;
    t = exp_take(k, f);
    hold = hold & t;
    n = 0;
    fs = 1'b0;
    @(posedge aclk);
    br_valid <= 1'b1;
    br_kind <= k;
    br_offset <= o;
    pc_in <= p;
    flags_in <= f;
    do begin
      @(posedge aclk);
      if (n == 1 || !hold) br_valid <= 1'b0;
      #1;
      n++;
      fs = fs | flush;
    end while (done !== 1'b1 && n < 8);
    if (n >= 8) begin
      chk(32'h0, 32'h1);
      test_done();
    end
    n_exec++;
    n_taken += t;
    chk(n, t ? CYC_TAKEN : CYC_NOT_TAKEN);
    chk(taken, t);
    chk(fs, t);
    chk(pc_load, 1'b1);
    chk(pc_target, t ? 16'(p + 16'($signed(o)) + 16'h1) : 16'(p + 16'h1));
    chk(flags_out, f);
  endtask : jump

  initial begin
    void'($urandom(32'ha406c33f));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk({busy, taken, pc_load, done, flush, flags_out, pc_target}, 32'h0);
    axi_rd(ADDR_CTRL, rd, rs);
    chk(rd[CTRL_ENABLE], CTRL_ENABLE_RST);
    // First sixteen sweep every kind code, unknown ones included, plus offset extremes
    for (int i = 0; i < 120; i++) begin
      jump(i < 16 ? 4'(i) : 4'($urandom % 9), i == 0 ? 7'h40 : i == 1 ? 7'h3f : 7'($urandom),
        16'($urandom), i < 16 ? 4'(15 - i) : 4'($urandom), 1'($urandom));
    end
    axi_rd(ADDR_TAKEN_CNT, rd, rs);
    chk(rd, n_taken);
    axi_rd(ADDR_EXEC_CNT, rd, rs);
    chk(rd, n_exec);
    axi_rd(ADDR_STATUS, rd, rs);
    chk(rd[STAT_BAD_KIND], 1'b1);
    axi_wr(ADDR_STATUS, 32'h4, rs);
    axi_rd(ADDR_STATUS, rd, rs);
    chk(rd[STAT_BAD_KIND], 1'b0);
    axi_wr(ADDR_CTRL, 32'h0, rs);
    chk(rs, RESP_OKAY);
    @(posedge aclk);
    br_valid <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      @(posedge aclk);
      #1;
      chk(done | pc_load | flush, 1'b0);
    end
    @(posedge aclk);
    br_valid <= 1'b0;
    axi_wr(ADDR_CTRL, 32'h1, rs);
    axi_wr(ADDR_TAKEN_CNT, 32'h0, rs);
    chk(rs, RESP_SLVERR);
    axi_rd(8'h10, rd, rs);
    chk(rd, 32'h0);
    chk(rs, RESP_SLVERR);
    // Back-to-back requests: a fall-through accepted, then a taken jump on the very next edge
    @(posedge aclk);
    br_valid <= 1'b1;
    br_kind <= KIND_JUMP_ON_CARRY_SET;
    br_offset <= 7'h02;
    pc_in <= 16'h0200;
    flags_in <= 4'h0;
    @(posedge aclk);
    br_kind <= KIND_JUMP_ON_CARRY_CLEAR;
    pc_in <= 16'h0300;
    #1;
    chk(done, 1'b1);
    chk(taken, 1'b0);
    chk(pc_target, 16'h0201);
    @(posedge aclk);
    br_valid <= 1'b0;
    #1;
    chk(flush, 1'b1);
    chk(done, 1'b0);
    @(posedge aclk);
    #1;
    chk(done, 1'b1);
    chk(taken, 1'b1);
    chk(pc_target, 16'h0303);
    jump(KIND_JUMP_ON_NEGATIVE, 7'h01, 16'h0100, 4'h2, 1'b0);
    axi_rd(ADDR_STATUS, rd, rs);
    chk(rd[STAT_KIND_LSB +: 4], KIND_JUMP_ON_NEGATIVE);
    chk(rd[STAT_LAST_TAKEN], 1'b1);
    chk(rd[STAT_BUSY], 1'b0);
    test_done();
  end
endmodule : test_conditional_branch_unit
